// [hw/csb_calib_host.sv]
// Host controller that selects the sensing plane and loads matching calibration
// Summary of operation
// - Copy factory temperature offsets matching selected plane into working offset fields.
// - Cold to low byte, hot to high byte; X/Y, X/ZY, Y/ZX per plane.
// - Repeat the offset copy every time the plane selection changes.
// - Copy matching sensitivity words into the two working sensitivity registers.
// - Sensitivity sources: XY/YY, X-ZY/ZZY, Y-ZX/ZZX for planes 0, 1, 2.
// - Sensitivity copy once at end of line, redone after a plane change.
// - With quadrature sensitivity at 2^15, gain results read uncompensated amplitudes.
// - Amplitude ratio is quadrature result divided by in-phase result.
// - Accept ratio 0.5 to 2 off-axis, otherwise 0.95 to 1.05.
// - Mid-field allows planes 0, 1, 2; high-field allows plane 0 only.
// - Off-axis variant uses plane 1 or plane 2.
// - Stray-field-immune variant uses plane 0 only.
// - All register access over the serial link; unused bits written as zero.
//
// The plain strobed port was decided locally.
`timescale 1ns/1ps
`default_nettype none
module csb_calib_host import csb_pkg::*; #(
	parameter int HALF_CYC = SPI_HALF_CYC
) (
	input  wire logic        CLK,
	input  wire logic        RST_B,
	input  wire logic [3:0]  ADDR,
	input  wire logic [15:0] WDATA,
	input  wire logic        WR,
	input  wire logic        RD,
	output logic      [15:0] RDATA,
	output logic             BUSY,
	output logic             SCLK,
	output logic             CS_N,
	output logic             MOSI,
	input  wire logic        MISO
);
	typedef enum logic [4:0] {
		S_IDLE,
		S_CFG_RD,
		S_CFG_WR,
		S_OFS_RD_I,
		S_OFS_RD_Q,
		S_OFS_WR_I,
		S_OFS_WR_Q,
		S_SNS_RD_I,
		S_SNS_RD_Q,
		S_SNS_WR_I,
		S_SNS_WR_Q,
		S_RAT_SAVE,
		S_RAT_FORCE,
		S_RAT_RD_I,
		S_RAT_RD_Q,
		S_RAT_RESTORE,
		S_RAW_RD,
		S_RAW_WR
	} csb_state_t;

	csb_state_t  state_ff;
	csb_state_t  nxt_state;
	csb_state_t  step_next;
	logic        pend_ff;
	logic        nxt_pend;
	logic        spi_start;
	logic        tx_rd;
	logic [8:0]  tx_addr;
	logic [15:0] tx_data;
	logic        spi_done;
	logic [15:0] spi_rdata;
	logic [2:0]  cfg_plane_ff;
	logic [1:0]  cfg_variant_ff;
	logic [2:0]  act_plane_ff;
	logic [2:0]  applied_plane_ff;
	logic [15:0] word_ff;
	logic [15:0] src_i_ff;
	logic [15:0] src_q_ff;
	logic [15:0] saved_q_ff;
	logic [15:0] gain_i_ff;
	logic [15:0] gain_q_ff;
	logic [8:0]  raw_addr_ff;
	logic [15:0] raw_data_ff;
	logic        busy_ff;
	logic        done_ff;
	logic        err_ff;
	logic        rvalid_ff;
	logic        rok_ff;
	logic        chk_start_ff;
	logic        chk_valid;
	logic        chk_ok;
	logic [15:0] rdata_ff;

	// Host port decode
	wire         idle      = (state_ff == S_IDLE);
	wire         wr_cmd    = WR & (ADDR == HR_CMD);
	wire         wr_cfg    = WR & (ADDR == HR_CFG);
	wire         wr_raw_a  = WR & (ADDR == HR_RAW_ADDR);
	wire         wr_raw_d  = WR & (ADDR == HR_RAW_DATA);
	wire         req_apply = wr_cmd & WDATA[CMD_APPLY];
	wire         req_copy  = wr_cmd & WDATA[CMD_COPY];
	wire         req_ratio = wr_cmd & WDATA[CMD_RATIO];
	wire         req_clear = wr_cmd & WDATA[CMD_CLEAR];
	wire         req_rawrd = wr_cmd & WDATA[CMD_RAW_RD];
	wire         req_rawwr = wr_cmd & WDATA[CMD_RAW_WR];
	wire         req_plane = req_apply | req_copy;

	// Planes each variant may use
	wire         plane_ok  =
		(cfg_variant_ff == VAR_MID)     ? (cfg_plane_ff <= PLANE_YZX) :
		(cfg_variant_ff == VAR_OFFAXIS) ? ((cfg_plane_ff == PLANE_XZY) ||
		                                   (cfg_plane_ff == PLANE_YZX)) :
		                                  (cfg_plane_ff == PLANE_XY);
	wire         go_plane  = idle & req_plane & plane_ok;
	wire         set_err   = idle & req_plane & ~plane_ok;
	wire         go_any    = idle & (go_plane | (~req_plane & (req_ratio | req_rawrd | req_rawwr)));

	// Factory source words per plane
	wire [8:0]   ofs_src_i =
		(act_plane_ff == PLANE_YZX) ? DEV_FAC_Y_OFFSET : DEV_FAC_X_OFFSET;
	wire [8:0]   ofs_src_q =
		(act_plane_ff == PLANE_XZY) ? DEV_FAC_ZY_OFFSET :
		(act_plane_ff == PLANE_YZX) ? DEV_FAC_ZX_OFFSET : DEV_FAC_Y_OFFSET;
	wire [8:0]   sns_src_i =
		(act_plane_ff == PLANE_XZY) ? DEV_FAC_SENS_P1_I :
		(act_plane_ff == PLANE_YZX) ? DEV_FAC_SENS_P2_I : DEV_FAC_SENS_P0_I;
	wire [8:0]   sns_src_q =
		(act_plane_ff == PLANE_XZY) ? DEV_FAC_SENS_P1_Q :
		(act_plane_ff == PLANE_YZX) ? DEV_FAC_SENS_P2_Q : DEV_FAC_SENS_P0_Q;
	// Read-modify-write keeps the other live fields of the word; bits above are untouched
	wire [15:0]  cfg_wr_word = {word_ff[15:PLANE_W], act_plane_ff};

	wire         step_done = pend_ff & spi_done;
	wire         seq_end   = step_done & (step_next == S_IDLE);
	wire         plane_end = step_done & (state_ff == S_SNS_WR_Q);

	// Per-step transaction table; any step not listed as a write is a read
	assign tx_rd     = !(state_ff inside {S_CFG_WR, S_OFS_WR_I, S_OFS_WR_Q, S_SNS_WR_I,
	                                      S_SNS_WR_Q, S_RAT_FORCE, S_RAT_RESTORE, S_RAW_WR});
	assign tx_addr   =
		(state_ff == S_OFS_RD_I) ? ofs_src_i :
		(state_ff == S_OFS_RD_Q) ? ofs_src_q :
		(state_ff == S_OFS_WR_I) ? DEV_OFFSET_I :
		(state_ff == S_OFS_WR_Q) ? DEV_OFFSET_Q :
		(state_ff == S_SNS_RD_I) ? sns_src_i :
		(state_ff == S_SNS_RD_Q) ? sns_src_q :
		(state_ff == S_SNS_WR_I) ? DEV_SENS_TRIM_I :
		(state_ff inside {S_SNS_WR_Q, S_RAT_SAVE, S_RAT_FORCE, S_RAT_RESTORE}) ?
		                           DEV_SENS_TRIM_Q :
		(state_ff == S_RAT_RD_I) ? DEV_GAIN_COMP_I :
		(state_ff == S_RAT_RD_Q) ? DEV_GAIN_COMP_Q :
		(state_ff inside {S_RAW_RD, S_RAW_WR}) ? raw_addr_ff : DEV_CFG_WORD;
	assign tx_data   =
		(state_ff == S_CFG_WR)                     ? cfg_wr_word :
		(state_ff inside {S_OFS_WR_I, S_SNS_WR_I}) ? src_i_ff :
		(state_ff inside {S_OFS_WR_Q, S_SNS_WR_Q}) ? src_q_ff :
		(state_ff == S_RAT_FORCE)                  ? SENS_UNCOMP :
		(state_ff == S_RAT_RESTORE)                ? saved_q_ff :
		(state_ff == S_RAW_WR)                     ? raw_data_ff : 16'h0000;
	assign step_next =
		(state_ff == S_CFG_RD)    ? S_CFG_WR :
		(state_ff == S_CFG_WR)    ? S_OFS_RD_I :
		(state_ff == S_OFS_RD_I)  ? S_OFS_RD_Q :
		(state_ff == S_OFS_RD_Q)  ? S_OFS_WR_I :
		(state_ff == S_OFS_WR_I)  ? S_OFS_WR_Q :
		(state_ff == S_OFS_WR_Q)  ? S_SNS_RD_I :
		(state_ff == S_SNS_RD_I)  ? S_SNS_RD_Q :
		(state_ff == S_SNS_RD_Q)  ? S_SNS_WR_I :
		(state_ff == S_SNS_WR_I)  ? S_SNS_WR_Q :
		(state_ff == S_RAT_SAVE)  ? S_RAT_FORCE :
		(state_ff == S_RAT_FORCE) ? S_RAT_RD_I :
		(state_ff == S_RAT_RD_I)  ? S_RAT_RD_Q :
		(state_ff == S_RAT_RD_Q)  ? S_RAT_RESTORE : S_IDLE;

	// Sequencer: one frame per step, next step after the frame completes
	always_comb
	begin
		nxt_state = state_ff;
		nxt_pend  = pend_ff;
		spi_start = 1'b0;
		case (state_ff)
			S_IDLE:
			begin
				nxt_pend = 1'b0;
				if (go_plane && req_apply)
					nxt_state = S_CFG_RD;
				else if (go_plane)
					nxt_state = S_OFS_RD_I;
				else if (idle && !req_plane && req_ratio)
					nxt_state = S_RAT_SAVE;
				else if (idle && !req_plane && req_rawrd)
					nxt_state = S_RAW_RD;
				else if (idle && !req_plane && req_rawwr)
					nxt_state = S_RAW_WR;
			end
			default:
			begin
				if (!pend_ff)
				begin
					spi_start = 1'b1;
					nxt_pend  = 1'b1;
				end
				else if (spi_done)
				begin
					nxt_pend  = 1'b0;
					nxt_state = step_next;
				end
			end
		endcase
	end

	always_ff @(posedge CLK or negedge RST_B)
	begin
		if (!RST_B)
		begin
			state_ff <= S_IDLE;
			pend_ff  <= 1'b0;
			busy_ff  <= 1'b0;
		end
		else
		begin
			state_ff <= nxt_state;
			pend_ff  <= nxt_pend;
			busy_ff  <= (nxt_state != S_IDLE);
		end
	end

	// Capture of read frames
	always_ff @(posedge CLK or negedge RST_B)
	begin
		if (!RST_B)
		begin
			word_ff    <= 16'h0000;
			src_i_ff   <= 16'h0000;
			src_q_ff   <= 16'h0000;
			saved_q_ff <= 16'h0000;
			gain_i_ff  <= 16'h0000;
			gain_q_ff  <= 16'h0000;
		end
		else if (step_done)
		begin
			case (state_ff)
				S_CFG_RD:   word_ff    <= spi_rdata;
				S_OFS_RD_I: src_i_ff   <= spi_rdata;
				S_OFS_RD_Q: src_q_ff   <= spi_rdata;
				S_SNS_RD_I: src_i_ff   <= spi_rdata;
				S_SNS_RD_Q: src_q_ff   <= spi_rdata;
				S_RAT_SAVE: saved_q_ff <= spi_rdata;
				S_RAT_RD_I: gain_i_ff  <= spi_rdata;
				S_RAT_RD_Q: gain_q_ff  <= spi_rdata;
				default:    word_ff    <= word_ff;
			endcase
		end
	end

	// Configuration and raw access registers; plane is frozen per sequence
	always_ff @(posedge CLK or negedge RST_B)
	begin
		if (!RST_B)
		begin
			cfg_plane_ff     <= PLANE_RST;
			cfg_variant_ff   <= VAR_MID;
			act_plane_ff     <= PLANE_RST;
			applied_plane_ff <= PLANE_RST;
			raw_addr_ff      <= 9'h000;
			raw_data_ff      <= 16'h0000;
		end
		else
		begin
			if (wr_cfg)
			begin
				cfg_plane_ff   <= WDATA[PLANE_LSB +: PLANE_W];
				cfg_variant_ff <= WDATA[CFG_VAR_LSB +: 2];
			end
			if (go_plane)
				act_plane_ff <= cfg_plane_ff;
			if (plane_end)
				applied_plane_ff <= act_plane_ff;
			if (wr_raw_a)
				raw_addr_ff <= WDATA[DEV_ADDR_W-1:0];
			if (step_done && state_ff == S_RAW_RD)
				raw_data_ff <= spi_rdata;
			else if (wr_raw_d)
				raw_data_ff <= WDATA;
		end
	end

	// Sticky status; a set in the same cycle as a clear wins
	always_ff @(posedge CLK or negedge RST_B)
	begin
		if (!RST_B)
		begin
			done_ff      <= 1'b0;
			err_ff       <= 1'b0;
			rvalid_ff    <= 1'b0;
			rok_ff       <= 1'b0;
			chk_start_ff <= 1'b0;
		end
		else
		begin
			done_ff      <= seq_end | (done_ff & ~req_clear & ~go_any);
			err_ff       <= set_err | (err_ff & ~req_clear);
			rvalid_ff    <= chk_valid | (rvalid_ff & ~req_clear);
			chk_start_ff <= step_done & (state_ff == S_RAT_RD_Q);
			if (chk_valid)
				rok_ff <= chk_ok;
		end
	end

	// Read port
	wire [15:0]  status_word = {11'h000, rok_ff, rvalid_ff, err_ff, done_ff, busy_ff};
	wire [15:0]  rd_mux =
		(ADDR == HR_CFG)      ? {10'h000, cfg_variant_ff, 1'b0, cfg_plane_ff} :
		(ADDR == HR_STATUS)   ? status_word :
		(ADDR == HR_GAIN_I)   ? gain_i_ff :
		(ADDR == HR_GAIN_Q)   ? gain_q_ff :
		(ADDR == HR_RAW_ADDR) ? {7'h00, raw_addr_ff} :
		(ADDR == HR_RAW_DATA) ? raw_data_ff :
		(ADDR == HR_APPLIED)  ? {13'h0000, applied_plane_ff} : 16'h0000;

	always_ff @(posedge CLK or negedge RST_B)
	begin
		if (!RST_B)
			rdata_ff <= 16'h0000;
		else
			rdata_ff <= RD ? rd_mux : 16'h0000;
	end

	assign RDATA = rdata_ff;
	assign BUSY  = busy_ff;

	csb_spi_master #(
		.HALF_CYC (HALF_CYC)
	) u_spi (
		.clk   (CLK),
		.rst_b (RST_B),
		.start (spi_start),
		.frame (csb_frame(tx_rd, tx_addr, tx_data)),
		.done  (spi_done),
		.rdata (spi_rdata),
		.sclk  (SCLK),
		.cs_n  (CS_N),
		.mosi  (MOSI),
		.miso  (MISO)
	);

	// Ratio Q over I, judged against the variant window
	csb_ratio_check u_ratio (
		.clk     (CLK),
		.rst_b   (RST_B),
		.start   (chk_start_ff),
		.variant (cfg_variant_ff),
		.amp_i   (gain_i_ff),
		.amp_q   (gain_q_ff),
		.valid   (chk_valid),
		.ok      (chk_ok)
	);
endmodule : csb_calib_host
`default_nettype wire

// [hw/csb_pkg.sv]
// Shared constants for the calibration select host controller
package csb_pkg;
	localparam int          CLK_PERIOD_NS  = 100;
	localparam int          SPI_HALF_NS    = 500;
	localparam int          SPI_HALF_CYC   = (SPI_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int          FRAME_W        = 32;
	localparam int          DATA_W         = 16;
	localparam int          DEV_ADDR_W     = 9;
	localparam int          HOST_ADDR_W    = 4;

	// Device register map
	localparam logic [8:0]  DEV_CFG_WORD        = 9'h100;
	localparam logic [8:0]  DEV_SENS_TRIM_I     = 9'h11C;
	localparam logic [8:0]  DEV_SENS_TRIM_Q     = 9'h11E;
	localparam logic [8:0]  DEV_OFFSET_I        = 9'h122;
	localparam logic [8:0]  DEV_OFFSET_Q        = 9'h124;
	localparam logic [8:0]  DEV_FAC_X_OFFSET    = 9'h176;
	localparam logic [8:0]  DEV_FAC_Y_OFFSET    = 9'h178;
	localparam logic [8:0]  DEV_FAC_ZX_OFFSET   = 9'h17A;
	localparam logic [8:0]  DEV_FAC_ZY_OFFSET   = 9'h17C;
	localparam logic [8:0]  DEV_FAC_SENS_P0_I   = 9'h186;
	localparam logic [8:0]  DEV_FAC_SENS_P1_I   = 9'h18A;
	localparam logic [8:0]  DEV_FAC_SENS_P2_I   = 9'h18C;
	localparam logic [8:0]  DEV_FAC_SENS_P0_Q   = 9'h190;
	localparam logic [8:0]  DEV_FAC_SENS_P2_Q   = 9'h192;
	localparam logic [8:0]  DEV_FAC_SENS_P1_Q   = 9'h194;
	localparam logic [8:0]  DEV_GAIN_COMP_I     = 9'h04A;
	localparam logic [8:0]  DEV_GAIN_COMP_Q     = 9'h04E;

	localparam int          PLANE_LSB      = 0;
	localparam int          PLANE_W        = 3;
	localparam logic [2:0]  PLANE_XY       = 3'h0;
	localparam logic [2:0]  PLANE_XZY      = 3'h1;
	localparam logic [2:0]  PLANE_YZX      = 3'h2;
	localparam logic [15:0] SENS_UNCOMP    = 16'h8000;

	// Device variants
	localparam logic [1:0]  VAR_MID        = 2'h0;
	localparam logic [1:0]  VAR_OFFAXIS    = 2'h1;
	localparam logic [1:0]  VAR_HIGH       = 2'h2;
	localparam logic [1:0]  VAR_STRAY      = 2'h3;

	// Ratio limits in percent
	localparam logic [7:0]  RATIO_SCALE    = 8'h64;
	localparam logic [7:0]  OFFAXIS_LO_PCT = 8'h32;
	localparam logic [7:0]  OFFAXIS_HI_PCT = 8'hC8;
	localparam logic [7:0]  NARROW_LO_PCT  = 8'h5F;
	localparam logic [7:0]  NARROW_HI_PCT  = 8'h69;

	// Host register map
	localparam logic [3:0]  HR_CMD         = 4'h0;
	localparam logic [3:0]  HR_CFG         = 4'h1;
	localparam logic [3:0]  HR_STATUS      = 4'h2;
	localparam logic [3:0]  HR_GAIN_I      = 4'h3;
	localparam logic [3:0]  HR_GAIN_Q      = 4'h4;
	localparam logic [3:0]  HR_RAW_ADDR    = 4'h5;
	localparam logic [3:0]  HR_RAW_DATA    = 4'h6;
	localparam logic [3:0]  HR_APPLIED     = 4'h7;

	localparam int          CMD_APPLY      = 0;
	localparam int          CMD_COPY       = 1;
	localparam int          CMD_RATIO      = 2;
	localparam int          CMD_CLEAR      = 3;
	localparam int          CMD_RAW_RD     = 4;
	localparam int          CMD_RAW_WR     = 5;
	localparam int          CFG_VAR_LSB    = 4;
	localparam int          ST_BUSY        = 0;
	localparam int          ST_DONE        = 1;
	localparam int          ST_PLANE_ERR   = 2;
	localparam int          ST_RATIO_VALID = 3;
	localparam int          ST_RATIO_OK    = 4;
	localparam logic [2:0]  PLANE_RST      = 3'h0;

	function automatic logic [31:0] csb_frame(input logic rd, input logic [8:0] addr,
		input logic [15:0] data);
		csb_frame = {rd, 6'h00, addr, data};
	endfunction : csb_frame
endpackage : csb_pkg

// [hw/csb_spi_master.sv]
// Register access frame engine towards the sensor
`timescale 1ns/1ps
`default_nettype none
module csb_spi_master import csb_pkg::*; #(
	parameter int HALF_CYC = SPI_HALF_CYC
) (
	input  wire logic        clk,
	input  wire logic        rst_b,
	input  wire logic        start,
	input  wire logic [31:0] frame,
	output logic             done,
	output logic [15:0]      rdata,
	output logic             sclk,
	output logic             cs_n,
	output logic             mosi,
	input  wire logic        miso
);
	logic        active_ff;
	logic [7:0]  cnt_ff;
	logic [4:0]  bit_ff;
	logic [31:0] tx_ff;
	logic [15:0] rx_ff;
	logic        miso_s1_ff;
	logic        miso_s2_ff;
	wire         half_tick = active_ff & (cnt_ff == 8'(HALF_CYC - 1));
	wire         last_bit  = (bit_ff == 5'h1F);

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			miso_s1_ff <= 1'b0;
			miso_s2_ff <= 1'b0;
			cnt_ff     <= 8'h00;
		end
		else
		begin
			miso_s1_ff <= miso;
			miso_s2_ff <= miso_s1_ff;
			cnt_ff     <= (!active_ff || half_tick) ? 8'h00 : cnt_ff + 8'h01;
		end
	end

	// Mode 0: data out on falling edge, sampled on rising edge
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			active_ff <= 1'b0;
			sclk      <= 1'b0;
			cs_n      <= 1'b1;
			mosi      <= 1'b0;
			bit_ff    <= 5'h00;
			tx_ff     <= 32'h0000_0000;
			rx_ff     <= 16'h0000;
			rdata     <= 16'h0000;
			done      <= 1'b0;
		end
		else
		begin
			done <= 1'b0;
			if (!active_ff && start)
			begin
				active_ff <= 1'b1;
				cs_n      <= 1'b0;
				tx_ff     <= frame;
				mosi      <= frame[FRAME_W-1];
				bit_ff    <= 5'h00;
			end
			else if (half_tick && !sclk)
			begin
				sclk  <= 1'b1;
				rx_ff <= {rx_ff[14:0], miso_s2_ff};
			end
			else if (half_tick)
			begin
				sclk <= 1'b0;
				if (last_bit)
				begin
					active_ff <= 1'b0;
					cs_n      <= 1'b1;
					mosi      <= 1'b0;
					rdata     <= rx_ff;
					done      <= 1'b1;
				end
				else
				begin
					bit_ff <= bit_ff + 5'h01;
					tx_ff  <= {tx_ff[30:0], 1'b0};
					mosi   <= tx_ff[FRAME_W-2];
				end
			end
		end
	end
endmodule : csb_spi_master
`default_nettype wire

// [hw/csb_ratio_check.sv]
// Amplitude ratio window check on uncompensated I and Q
`timescale 1ns/1ps
`default_nettype none
module csb_ratio_check import csb_pkg::*; (
	input  wire logic        clk,
	input  wire logic        rst_b,
	input  wire logic        start,
	input  wire logic [1:0]  variant,
	input  wire logic [15:0] amp_i,
	input  wire logic [15:0] amp_q,
	output logic             valid,
	output logic             ok
);
	// Division avoided: Q*100 compared against I times the limit percentages
	wire         offaxis  = (variant == VAR_OFFAXIS);
	wire [7:0]   lo_pct   = offaxis ? OFFAXIS_LO_PCT : NARROW_LO_PCT;
	wire [7:0]   hi_pct   = offaxis ? OFFAXIS_HI_PCT : NARROW_HI_PCT;
	wire [23:0]  q_scaled = 24'(amp_q) * 24'(RATIO_SCALE);
	wire [23:0]  i_lo     = 24'(amp_i) * 24'(lo_pct);
	wire [23:0]  i_hi     = 24'(amp_i) * 24'(hi_pct);
	wire         in_win   = (amp_i != 16'h0000) && (q_scaled >= i_lo) && (q_scaled <= i_hi);

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			valid <= 1'b0;
			ok    <= 1'b0;
		end
		else
		begin
			valid <= start;
			if (start)
				ok <= in_win;
		end
	end
endmodule : csb_ratio_check
`default_nettype wire

// [verification/csb_calib_host_chk.sv]
// Port checker for the calibration host controller
`timescale 1ns/1ps
`default_nettype none
module csb_calib_host_chk import csb_pkg::*; (
	input wire logic        CLK,
	input wire logic        RST_B,
	input wire logic [3:0]  ADDR,
	input wire logic [15:0] WDATA,
	input wire logic        WR,
	input wire logic        RD,
	input wire logic [15:0] RDATA,
	input wire logic        BUSY,
	input wire logic        SCLK,
	input wire logic        CS_N,
	input wire logic        MOSI,
	input wire logic        MISO
);
	logic [5:0] edge_cnt_ff;
	logic       sclk_q_ff;
	// Rising serial edges within one frame
	always_ff @(posedge CLK or negedge RST_B)
	begin
		if (!RST_B)
			edge_cnt_ff <= 6'h00;
		else
			edge_cnt_ff <= CS_N ? 6'h00 : edge_cnt_ff + {5'h00, SCLK & ~sclk_q_ff};
	end
	always_ff @(posedge CLK or negedge RST_B)
	begin
		if (!RST_B)
			sclk_q_ff <= 1'b0;
		else
			sclk_q_ff <= SCLK;
	end
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RST_B);
	sequence s_raw_cmd;
		WR && ADDR == HR_CMD && WDATA == 16'h0010 && !BUSY;
	endsequence
	sequence s_frame_open;
		##[1:2] BUSY ##[0:4] !CS_N;
	endsequence
	a_rdata_zero: assert property (!RD |=> RDATA == 16'h0000)
		else $error("read data not cleared");
	a_unmapped_zero: assert property (RD && ADDR[3] |=> RDATA == 16'h0000)
		else $error("unmapped read gave data");
	a_sclk_idle: assert property (CS_N |-> !SCLK)
		else $error("serial clock moved outside frame");
	a_mosi_idle: assert property (CS_N |-> !MOSI)
		else $error("data out high outside frame");
	a_cs_gap: assert property ($rose(CS_N) |-> CS_N [*2])
		else $error("select gap too short");
	a_mosi_hold: assert property (SCLK |-> $stable(MOSI))
		else $error("data out moved while clock high");
	a_frame_bits: assert property ($rose(CS_N) |-> edge_cnt_ff == 6'h20)
		else $error("frame not 32 bits");
	a_busy_frames: assert property (!BUSY |-> CS_N)
		else $error("frame while idle");
	a_raw_starts: assert property (s_raw_cmd |-> s_frame_open)
		else $error("raw read started no frame");
endmodule : csb_calib_host_chk
bind csb_calib_host csb_calib_host_chk csb_calib_host_chk_inst (.CLK(CLK), .RST_B(RST_B),
	.ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .BUSY(BUSY),
	.SCLK(SCLK), .CS_N(CS_N), .MOSI(MOSI), .MISO(MISO));
`default_nettype wire

// [verification/csb_dev_model.sv]
// Behavioural sensor model answering register frames
`timescale 1ns/1ps
`default_nettype none
module csb_dev_model (
	input  wire logic        sclk,
	input  wire logic        cs_n,
	input  wire logic        mosi,
	output logic             miso,
	input  wire logic [15:0] amp_i,
	input  wire logic [15:0] amp_q
);
	logic [15:0] mem [0:511];
	logic [31:0] sh;
	logic [15:0] rv;
	int          cnt;
	initial
	begin
		for (int i = 0; i < 512; i++)
			mem[i] = 16'h0000;
		mem[9'h100] = 16'h0A28;
		mem[9'h176] = 16'hA1B2;
		mem[9'h178] = 16'hC3D4;
		mem[9'h17A] = 16'hE5F6;
		mem[9'h17C] = 16'h1728;
		mem[9'h186] = 16'h4101;
		mem[9'h18A] = 16'h4202;
		mem[9'h18C] = 16'h4303;
		mem[9'h190] = 16'h5101;
		mem[9'h192] = 16'h5303;
		mem[9'h194] = 16'h5202;
		mem[9'h122] = 16'hA1B2;
		mem[9'h124] = 16'hC3D4;
		mem[9'h11C] = 16'h4101;
		mem[9'h11E] = 16'h5101;
		miso = 1'b0;
		cnt = 0;
	end
	// Results follow the working trim, so a host that skips the 2^15 step sees skewed values
	function automatic logic [15:0] rd_val(input logic [8:0] a);
		if (a == 9'h04A || a == 9'h04E)
			rd_val = (a == 9'h04A ? amp_i : amp_q) ^ (mem[9'h11E] ^ 16'h8000);
		else
			rd_val = mem[a];
	endfunction : rd_val
	always @(negedge cs_n)
		cnt = 0;
	always @(posedge cs_n)
		miso = ~miso;
	always @(posedge sclk)
	begin
		if (!cs_n)
		begin
			sh = {sh[30:0], mosi};
			cnt = cnt + 1;
			if (cnt == 32 && !sh[31] && sh[24:16] inside {9'h100, 9'h11C, 9'h11E, 9'h122, 9'h124})
				mem[sh[24:16]] = sh[15:0];
		end
	end
	// Line toggles when not carrying read data, never a stale bit
	always @(negedge sclk)
	begin
		if (!cs_n)
		begin
			if (cnt == 16)
				rv = rd_val(sh[8:0]);
			miso = (cnt >= 16 && cnt < 32) ? rv[31 - cnt] : ~miso;
		end
	end
endmodule : csb_dev_model
`default_nettype wire

// [verification/testbench.sv]
// Self-checking bench for the calibration host controller
`timescale 1ns/1ps
`default_nettype none
module testbench import csb_pkg::*;;
	logic        clk = 1'b0;
	logic        rst_b = 1'b0;
	logic [3:0]  addr = 4'h0;
	logic [15:0] wdata = 16'h0000;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic [15:0] amp_i = 16'h0064;
	logic [15:0] amp_q = 16'h0064;
	logic [15:0] rdata, d;
	logic        busy, sclk, cs_n, mosi, miso;
	int          err_total = 0;
	int          total_checks = 0;
	int          frames = 0;
	int          f0, p, n;
	logic [15:0] ofs_i [3] = '{16'hA1B2, 16'hA1B2, 16'hC3D4};
	logic [15:0] ofs_q [3] = '{16'hC3D4, 16'h1728, 16'hE5F6};
	logic [15:0] sen_i [3] = '{16'h4101, 16'h4202, 16'h4303};
	logic [15:0] sen_q [3] = '{16'h5101, 16'h5202, 16'h5303};
	logic [7:0]  rows [8] = '{8'h01, 8'h02, 8'h00, 8'h29, 8'h18, 8'h0B, 8'h30, 8'h12};
	logic [33:0] rr [8] = '{{2'h3, 16'h0064, 16'h00C8}, {2'h2, 16'h0064, 16'h00C9},
		{2'h3, 16'h00C8, 16'h0064}, {2'h2, 16'h00C9, 16'h0064},
		{2'h1, 16'h0064, 16'h0069}, {2'h0, 16'h0064, 16'h006A},
		{2'h1, 16'h0064, 16'h005F}, {2'h0, 16'h0064, 16'h005E}};
	csb_calib_host csb_calib_host_inst (.CLK(clk), .RST_B(rst_b), .ADDR(addr), .WDATA(wdata),
		.WR(wr), .RD(rd), .RDATA(rdata), .BUSY(busy), .SCLK(sclk), .CS_N(cs_n),
		.MOSI(mosi), .MISO(miso));
	csb_dev_model csb_dev_model_inst (.sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso),
		.amp_i(amp_i), .amp_q(amp_q));
	always #50 clk = ~clk;
	always @(negedge cs_n) frames++;
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			err_total++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic peek(input logic [8:0] a, input logic [15:0] exp);
		chk(csb_dev_model_inst.mem[a], exp);
	endtask : peek
	task automatic bus_wr(input logic [3:0] a, input logic [15:0] v);
		@(posedge clk);
		wr    <= 1'b1;
		addr  <= a;
		wdata <= v;
		@(posedge clk);
		wr    <= 1'b0;
	endtask : bus_wr
	task automatic bus_rd(input logic [3:0] a);
		@(posedge clk);
		rd   <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd   <= 1'b0;
		#1 d = rdata;
	endtask : bus_rd
	task automatic wait_idle;
		repeat (3) @(posedge clk);
		#1;
		for (n = 0; busy !== 1'b0 && n < 8000; n++)
			#100;
		chk({15'h0000, busy}, 16'h0000);
	endtask : wait_idle
	task automatic raw_rd(input logic [15:0] a);
		bus_wr(HR_RAW_ADDR, a);
		bus_wr(HR_CMD, 16'h0010);
		wait_idle();
		bus_rd(HR_RAW_DATA);
	endtask : raw_rd
	task automatic conclude;
		$display("Checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : conclude
	initial
	begin
		#(100 * 90000);
		err_total++;
		conclude();
	end
	initial
	begin
		repeat (8) @(posedge clk);
		rst_b <= 1'b1;
		bus_rd(HR_STATUS);
		chk(d, 16'h0000);
		bus_rd(HR_APPLIED);
		chk(d, 16'h0000);
		bus_rd(4'h9);
		chk(d, 16'h0000);
		raw_rd(16'h0122);
		chk(d, 16'hA1B2);
		raw_rd(16'h011E);
		chk(d, 16'h5101);
		bus_rd(HR_RAW_ADDR);
		chk(d, 16'h011E);
		bus_wr(HR_RAW_ADDR, 16'h011C);
		bus_wr(HR_RAW_DATA, 16'h1234);
		bus_wr(HR_CMD, 16'h0020);
		wait_idle();
		peek(9'h11C, 16'h1234);
		// Planes and variants, then a command sent while busy must be dropped
		for (int k = 0; k < 8; k++)
		begin
			p = rows[k][1:0];
			bus_wr(HR_CMD, 16'h0008);
			bus_wr(HR_CFG, {8'h00, rows[k] & 8'h37});
			bus_rd(HR_CFG);
			chk(d, {8'h00, rows[k] & 8'h37});
			f0 = frames;
			bus_wr(HR_CMD, 16'h0001);
			if (!rows[k][3])
				bus_wr(HR_CMD, 16'h0020);
			wait_idle();
			bus_rd(HR_STATUS);
			if (rows[k][3])
			begin
				chk(d & 16'h0004, 16'h0004);
				chk(16'(frames - f0), 16'h0000);
			end
			else
			begin
				chk(d & 16'h0006, 16'h0002);
				chk(16'(frames - f0), 16'h000A);
				bus_rd(HR_APPLIED);
				chk(d, {13'h0000, rows[k][2:0]});
				peek(9'h100, 16'h0A28 | {13'h0000, rows[k][2:0]});
				peek(9'h122, ofs_i[p]);
				peek(9'h124, ofs_q[p]);
				peek(9'h11C, sen_i[p]);
				peek(9'h11E, sen_q[p]);
			end
		end
		bus_wr(HR_CFG, 16'h0001);
		f0 = frames;
		bus_wr(HR_CMD, 16'h0002);
		wait_idle();
		chk(16'(frames - f0), 16'h0008);
		peek(9'h124, ofs_q[1]);
		peek(9'h11E, sen_q[1]);
		peek(9'h100, 16'h0A2A);
		for (int k = 0; k < 8; k++)
		begin
			@(posedge clk);
			amp_i <= rr[k][31:16];
			amp_q <= rr[k][15:0];
			bus_wr(HR_CMD, 16'h0008);
			bus_wr(HR_CFG, rr[k][33] ? 16'h0011 : 16'h0000);
			bus_wr(HR_CMD, 16'h0004);
			wait_idle();
			bus_rd(HR_STATUS);
			chk(d & 16'h0018, {11'h000, rr[k][32], 4'h8});
			bus_rd(HR_GAIN_I);
			chk(d, rr[k][31:16]);
			bus_rd(HR_GAIN_Q);
			chk(d, rr[k][15:0]);
			peek(9'h11E, 16'h5202);
		end
		conclude();
	end
endmodule : testbench
`default_nettype wire
